// *** logic/dpg_consts.svh ***
// Register offsets, reset values and timing counts of the driver PWM generator
`ifndef DPG_CONSTS_SVH
`define DPG_CONSTS_SVH

// Register offsets
`define DPG_OFS_MOD_EN       8'h1b
`define DPG_OFS_PRESCALE     8'h1c
`define DPG_OFS_DUTY         8'h1d
`define DPG_OFS_STATUS       8'h1e
`define DPG_OFS_COUNT        8'h1f

// Reset values
`define DPG_RST_MOD_EN       8'h00
`define DPG_RST_PRESCALE     8'h00
`define DPG_RST_DUTY         8'h00
`define DPG_READ_UNMAPPED    8'h00

// Modulation enable layout: half-bridge 4..1 in bits 3..0, high-side 4..1 in bits 7..4
`define DPG_HB_LSB           0
`define DPG_HS_LSB           4
`define DPG_NUM_DRIVERS      8

// Status register fields
`define DPG_STAT_RUNNING     0
`define DPG_STAT_PWM         1
`define DPG_STAT_GEN_ON      2

// Timing: oscillator rate, fixed divider and counter span
`define DPG_OSC_HZ           20000000
`define DPG_FIXED_DIV        80
`define DPG_COUNT_SPAN       256
`define DPG_COUNT_LAST       8'hff
`define DPG_COUNT_ZERO       8'h00

`endif

// *** logic/dpg_pkg.sv ***
// Types shared by the driver PWM generator modules
package dpg_pkg;

   typedef logic [7:0] dpg_byte_t;
   typedef logic [7:0] dpg_addr_t;

endpackage

// *** logic/dpg_if.sv ***
// Carrier for the PWM timing signals from the generator to the driver gates
`timescale 1ns/1ns

interface dpg_if;
   logic pwm;
   logic zero_cross;
   logic running;

   modport gen
   (
      output pwm,
      output zero_cross,
      output running
   );

   modport gate
   (
      input  pwm,
      input  zero_cross,
      input  running
   );
endinterface

// *** logic/dpg_gate.sv ***
// Per-driver gate: aligns a driver enable to the PWM period and forms the drive level
`timescale 1ns/1ns

module dpg_gate
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_sync_n,
   // PWM timing
   dpg_if.gate       pwm_bus,
   // Driver control
   input  wire logic drive_enable,
   input  wire logic modulate_enable,
   // Drive level
   output logic      driver_out
);

   logic en_sync_reg;
   logic en_sync_next;

   always_comb
   begin
      if (!drive_enable)
         en_sync_next = 1'b0;
      else if (!modulate_enable)
         en_sync_next = 1'b1;
      else if (!pwm_bus.running)
         en_sync_next = 1'b1;
      else if (pwm_bus.zero_cross)
         en_sync_next = 1'b1;
      else
         en_sync_next = en_sync_reg;
   end

   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         en_sync_reg <= 1'b0;
      else
         en_sync_reg <= en_sync_next;
   end

   // Modulated drivers follow the PWM level, others are fully on
   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         driver_out <= 1'b0;
      else
         driver_out <= en_sync_next & (modulate_enable ? pwm_bus.pwm : 1'b1);
   end

endmodule

// *** logic/dpg_top.sv ***
// Top of the driver PWM generator: registers, prescaler, period counter and drivers
`timescale 1ns/1ns
`include "dpg_consts.svh"

module dpg_top
#(
   parameter int unsigned FIXED_DIV = `DPG_FIXED_DIV
)
(
   // Clock and reset
   input  logic                  core_clk,
   input  logic                  rst_n,
   // Register access
   input  logic                  reg_wr,
   input  logic                  reg_rd,
   input  dpg_pkg::dpg_addr_t    reg_addr,
   input  dpg_pkg::dpg_byte_t    reg_wdata,
   output dpg_pkg::dpg_byte_t    reg_rdata,
   // Power manager
   input  logic                  sleep_entry,
   // Driver enables from the driver control registers
   input  logic [7:0]            drive_enable,
   // Generator state
   output logic                  pwm_out,
   output logic                  pwm_running,
   // Drive levels to the output stages
   output logic [7:0]            driver_out
);

   localparam logic [6:0] FIX_LAST = 7'(FIXED_DIV - 1);

   // Reset release
   logic                rst_meta_reg;
   logic                rst_sync_reg;
   logic                rst_sync_n;

   // Software registers
   dpg_pkg::dpg_byte_t  driver_modulation_enables_reg;
   dpg_pkg::dpg_byte_t  period_prescale_setting_reg;
   dpg_pkg::dpg_byte_t  duty_setting_reg;
   dpg_pkg::dpg_byte_t  rdata_reg;

   // Generator state
   logic [6:0]          fix_cnt_reg;
   logic [7:0]          pre_cnt_reg;
   logic [7:0]          cnt_reg;
   logic [7:0]          cnt_next;
   logic [7:0]          shadow_reg;
   logic                started_reg;
   logic                pwm_reg;
   logic                zero_cross_reg;
   logic                running_reg;

   // Decodes
   logic                gen_on;
   logic                fix_last;
   logic                tick;
   logic                start;
   logic                wrap;
   logic                zero_cross;
   logic                wr_mod_en;
   logic                wr_prescale;
   logic                wr_duty;
   logic [7:0]          highside_modulate_enable;
   logic [7:0]          halfbridge_modulate_enable;
   logic [7:0]          modulate_map;

   dpg_if pwm_bus ();

   // Asynchronous assertion, two-stage synchronous release
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   assign rst_sync_n = rst_sync_reg;

   // Register write decode
   assign wr_mod_en   = reg_wr && (reg_addr == `DPG_OFS_MOD_EN);
   assign wr_prescale = reg_wr && (reg_addr == `DPG_OFS_PRESCALE);
   assign wr_duty     = reg_wr && (reg_addr == `DPG_OFS_DUTY);

   // Modulation enables: locked while duty nonzero, cleared on sleep entry
   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         driver_modulation_enables_reg <= `DPG_RST_MOD_EN;
      else if (sleep_entry)
         driver_modulation_enables_reg <= `DPG_RST_MOD_EN;
      else if (wr_mod_en && (duty_setting_reg == `DPG_COUNT_ZERO))
         driver_modulation_enables_reg <= reg_wdata;
   end

   // Prescale setting survives sleep entry
   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         period_prescale_setting_reg <= `DPG_RST_PRESCALE;
      else if (wr_prescale)
         period_prescale_setting_reg <= reg_wdata;
   end

   // Duty setting, writable at any time, zero after reset and on sleep entry
   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         duty_setting_reg <= `DPG_RST_DUTY;
      else if (sleep_entry)
         duty_setting_reg <= `DPG_RST_DUTY;
      else if (wr_duty)
         duty_setting_reg <= reg_wdata;
   end

   // Generator runs only with some modulation bit set
   assign gen_on = |driver_modulation_enables_reg;

   // Fixed divide by the oscillator ratio, then the programmable prescaler
   assign fix_last = (fix_cnt_reg == FIX_LAST);
   assign tick     = fix_last && (pre_cnt_reg >= period_prescale_setting_reg);

   // Zero crossing: first period after enabling, and every wrap
   assign start      = gen_on && !started_reg;
   assign wrap       = started_reg && tick && (cnt_reg == `DPG_COUNT_LAST);
   assign zero_cross = start || wrap;

   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         fix_cnt_reg <= 7'h00;
      else if (!gen_on || start || fix_last)
         fix_cnt_reg <= 7'h00;
      else
         fix_cnt_reg <= fix_cnt_reg + 7'h01;
   end

   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         pre_cnt_reg <= 8'h00;
      else if (!gen_on || start || tick)
         pre_cnt_reg <= 8'h00;
      else if (fix_last)
         pre_cnt_reg <= pre_cnt_reg + 8'h01;
   end

   always_comb
   begin
      if (!gen_on || start)
         cnt_next = `DPG_COUNT_ZERO;
      else if (tick)
         cnt_next = cnt_reg + 8'h01;
      else
         cnt_next = cnt_reg;
   end

   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         cnt_reg <= `DPG_COUNT_ZERO;
      else
         cnt_reg <= cnt_next;
   end

   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         started_reg <= 1'b0;
      else
         started_reg <= gen_on;
   end

   // Shadow duty taken only at period boundaries
   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         shadow_reg <= `DPG_RST_DUTY;
      else if (!gen_on)
         shadow_reg <= `DPG_RST_DUTY;
      else if (zero_cross)
         shadow_reg <= duty_setting_reg;
   end

   // Comparator output
   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         pwm_reg <= 1'b0;
      else if (!gen_on)
         pwm_reg <= 1'b0;
      else if (zero_cross)
         pwm_reg <= (duty_setting_reg != `DPG_COUNT_ZERO);
      else if (tick && (cnt_next == shadow_reg))
         pwm_reg <= 1'b0;
   end

   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         zero_cross_reg <= 1'b0;
      else
         zero_cross_reg <= zero_cross;
   end

   // Running while enabled with a nonzero duty in effect
   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         running_reg <= 1'b0;
      else if (!gen_on)
         running_reg <= 1'b0;
      else if (zero_cross)
         running_reg <= (duty_setting_reg != `DPG_COUNT_ZERO);
   end

   assign pwm_bus.pwm        = pwm_reg;
   assign pwm_bus.zero_cross = zero_cross_reg;
   assign pwm_bus.running    = running_reg;

   // Register read port, answer one cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         rdata_reg <= `DPG_READ_UNMAPPED;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `DPG_OFS_MOD_EN:   rdata_reg <= driver_modulation_enables_reg;
            `DPG_OFS_PRESCALE: rdata_reg <= period_prescale_setting_reg;
            `DPG_OFS_DUTY:     rdata_reg <= duty_setting_reg;
            `DPG_OFS_STATUS:
            begin
               rdata_reg                   <= 8'h00;
               rdata_reg[`DPG_STAT_RUNNING] <= running_reg;
               rdata_reg[`DPG_STAT_PWM]     <= pwm_reg;
               rdata_reg[`DPG_STAT_GEN_ON]  <= gen_on;
            end
            `DPG_OFS_COUNT:    rdata_reg <= cnt_reg;
            default:           rdata_reg <= `DPG_READ_UNMAPPED;
         endcase
      end
   end

   assign reg_rdata   = rdata_reg;
   assign pwm_out     = pwm_reg;
   assign pwm_running = running_reg;

   // Driver order: half-bridge 1..4 then high-side 1..4
   always_comb
   begin
      halfbridge_modulate_enable = 8'h00;
      highside_modulate_enable   = 8'h00;
      halfbridge_modulate_enable[3:0] =
         driver_modulation_enables_reg[`DPG_HB_LSB +: 4];
      highside_modulate_enable[3:0] =
         driver_modulation_enables_reg[`DPG_HS_LSB +: 4];
      modulate_map = {highside_modulate_enable[3:0], halfbridge_modulate_enable[3:0]};
   end

   for (genvar i = 0; i < `DPG_NUM_DRIVERS; i++)
   begin : g_gate
      dpg_gate u_gate
      (
         .core_clk        (core_clk),
         .rst_sync_n      (rst_sync_n),
         .pwm_bus         (pwm_bus),
         .drive_enable    (drive_enable[i]),
         .modulate_enable (modulate_map[i]),
         .driver_out      (driver_out[i])
      );
   end

endmodule

// *** bench/dpg_top_assertions.sv ***
// Port-level checker of the driver PWM generator
`timescale 1ns/1ns

module dpg_top_assertions
#(
   parameter int unsigned FIXED_DIV = 80
)
(
   // Clock and reset
   input logic               core_clk,
   input logic               rst_n,
   // Register access
   input logic               reg_wr,
   input logic               reg_rd,
   input dpg_pkg::dpg_addr_t reg_addr,
   input dpg_pkg::dpg_byte_t reg_wdata,
   input dpg_pkg::dpg_byte_t reg_rdata,
   // Power manager and drivers
   input logic               sleep_entry,
   input logic [7:0]         drive_enable,
   input logic               pwm_out,
   input logic               pwm_running,
   input logic [7:0]         driver_out
);
   int unsigned hi;
   int unsigned gap;

   // High-time length and distance between rises while running
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hi  <= 0;
         gap <= 0;
      end
      else
      begin
         hi <= pwm_out ? hi + 1 : 0;
         if ($rose(pwm_out))
            gap <= 1;
         else
            gap <= (pwm_running && gap != 0) ? gap + 1 : 0;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_reset_low;
      $rose(rst_n) |-> !pwm_out && !pwm_running && driver_out == 8'h00 && reg_rdata == 8'h00;
   endproperty
   a_reset_low: assert property (p_reset_low)
      else $error("outputs not low at reset release");
   property p_first_rise;
      $rose(pwm_running) |-> pwm_out;
   endproperty
   a_first_rise: assert property (p_first_rise)
      else $error("pwm low at start of run");
   property p_idle_low;
      !pwm_running [*2] |-> !pwm_out;
   endproperty
   a_idle_low: assert property (p_idle_low)
      else $error("pwm high while stopped");
   property p_period;
      $rose(pwm_out) && gap != 0 |-> gap % (256 * FIXED_DIV) == 0;
   endproperty
   a_period: assert property (p_period)
      else $error("period not whole count sequence");
   property p_high;
      $fell(pwm_out) && pwm_running && !$past(sleep_entry) && !$past(sleep_entry, 2)
         |-> hi % FIXED_DIV == 0;
   endproperty
   a_high: assert property (p_high)
      else $error("high time not whole counter steps");
   property p_sleep_clear;
      sleep_entry |-> ##[1:2] (!pwm_out && !pwm_running);
   endproperty
   a_sleep_clear: assert property (p_sleep_clear)
      else $error("sleep entry left pwm running");
   property p_sleep_read;
      sleep_entry ##1 (reg_rd && reg_addr == 8'h1b) |=> reg_rdata == 8'h00;
   endproperty
   a_sleep_read: assert property (p_sleep_read)
      else $error("enables not cleared by sleep");
   property p_drive_off;
      drive_enable != 8'hff |=> (driver_out & ~$past(drive_enable)) == 8'h00;
   endproperty
   a_drive_off: assert property (p_drive_off)
      else $error("disabled driver driven");
endmodule

bind dpg_top dpg_top_assertions #(.FIXED_DIV(FIXED_DIV)) u_dpg_top_assertions
(
   .core_clk (core_clk), .rst_n (rst_n), .reg_wr (reg_wr), .reg_rd (reg_rd),
   .reg_addr (reg_addr), .reg_wdata (reg_wdata), .reg_rdata (reg_rdata),
   .sleep_entry (sleep_entry), .drive_enable (drive_enable), .pwm_out (pwm_out),
   .pwm_running (pwm_running), .driver_out (driver_out)
);

// *** bench/dpg_stage_model.sv ***
// Behavioural model of the half-bridge and high-side output stages
`timescale 1ns/1ns

module dpg_stage_model
(
   // Clock and measurement clear
   input  wire logic        core_clk,
   input  wire logic        clr,
   // Drive levels and per-stage on time
   input  wire logic [7:0]  driver_out,
   output logic [7:0][15:0] on_cycles
);
   logic [7:0] level_q;

   // Each stage follows its drive level one cycle late
   always_ff @(posedge core_clk)
   begin
      level_q <= driver_out;
      for (int i = 0; i < 8; i++)
         on_cycles[i] <= clr ? 16'h0000 : on_cycles[i] + 16'(level_q[i]);
   end
endmodule

// *** bench/dpg_top_tb.sv ***
// Self-checking bench of the driver PWM generator
`timescale 1ns/1ns
`include "dpg_consts.svh"

module dpg_top_tb;
   localparam int DIV = 2;
   localparam int PER = 256 * DIV;

   typedef struct {logic [7:0] duty; logic [7:0] mod; logic [7:0] den;} dpg_row_s;

   logic               core_clk, rst_n, reg_wr, reg_rd, sleep_entry, clr;
   dpg_pkg::dpg_addr_t reg_addr;
   dpg_pkg::dpg_byte_t reg_wdata, reg_rdata;
   logic [7:0]         drive_enable, driver_out;
   logic               pwm_out, pwm_running;
   logic [7:0][15:0]   on_cycles;
   int                 num_errors, n_checks, cnt;
   dpg_row_s           rows [3] = '{'{8'h80, 8'h01, 8'h01}, '{8'hff, 8'h81, 8'hff},
                                    '{8'h01, 8'h3c, 8'h0f}};

   dpg_top #(.FIXED_DIV(DIV)) u_dpg_top
   (
      .core_clk (core_clk), .rst_n (rst_n), .reg_wr (reg_wr), .reg_rd (reg_rd),
      .reg_addr (reg_addr), .reg_wdata (reg_wdata), .reg_rdata (reg_rdata),
      .sleep_entry (sleep_entry), .drive_enable (drive_enable), .pwm_out (pwm_out),
      .pwm_running (pwm_running), .driver_out (driver_out)
   );
   dpg_stage_model u_dpg_stage_model
   (.core_clk (core_clk), .clr (clr), .driver_out (driver_out), .on_cycles (on_cycles));

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One register access; a spare cycle keeps strobes from being set twice at one edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      {reg_wr, reg_rd} = {w, !w};
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      {reg_wr, reg_rd} = 2'b00;
      @(negedge core_clk);
   endtask

   function automatic logic sig(input int s);
      case (s)
         0: return pwm_out;
         1: return !pwm_running;
         2: return driver_out[0];
         default: return !pwm_out;
      endcase
   endfunction

   task automatic wait_sig(input int s);
      cnt = 0;
      while (sig(s) !== 1'b1 && cnt < 4 * PER)
      begin
         @(negedge core_clk);
         cnt++;
      end
      if (cnt >= 4 * PER)
      begin
         num_errors++;
         $display("ERROR wait_sig %0d expected 1 seen timeout", s);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial
   begin
      repeat (60000) @(posedge core_clk);
      num_errors++;
      wrap_up();
   end

   initial
   begin
      {rst_n, reg_wr, reg_rd, sleep_entry, clr} = 5'b00000;
      {reg_addr, reg_wdata, drive_enable} = 24'h000000;
      {num_errors, n_checks} = 0;
      repeat (6) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      check("pwm_out", 16'h0000, 16'(pwm_out));
      acc(0, `DPG_OFS_DUTY, 8'h00);
      check("duty", 16'h0000, 16'(reg_rdata));
      acc(0, `DPG_OFS_MOD_EN, 8'h00);
      check("enables", 16'h0000, 16'(reg_rdata));
      acc(1, `DPG_OFS_DUTY, 8'h40);
      repeat (PER + 8) @(negedge core_clk);
      check("running", 16'h0000, 16'({pwm_running, pwm_out}));
      foreach (rows[r])
      begin
         acc(1, `DPG_OFS_DUTY, 8'h00);
         repeat (PER + 8) @(negedge core_clk);
         acc(1, `DPG_OFS_MOD_EN, rows[r].mod);
         drive_enable = rows[r].den;
         repeat (2) @(negedge core_clk);
         check("off before duty", 16'h0000, 16'(driver_out & rows[r].mod));
         acc(1, `DPG_OFS_DUTY, rows[r].duty);
         repeat (PER) @(negedge core_clk);
         clr = 1'b1;
         @(negedge core_clk);
         clr = 1'b0;
         repeat (PER) @(negedge core_clk);
         for (int i = 0; i < 8; i++)
            check("on time", 16'(!rows[r].den[i] ? 0 : rows[r].mod[i] ? rows[r].duty * DIV
                  : PER), on_cycles[i]);
      end
      acc(1, `DPG_OFS_MOD_EN, 8'h00);
      acc(0, `DPG_OFS_MOD_EN, 8'h00);
      check("locked enables", 16'h003c, 16'(reg_rdata));
      acc(1, `DPG_OFS_DUTY, 8'h00);
      repeat (PER + 8) @(negedge core_clk);
      acc(1, `DPG_OFS_MOD_EN, 8'h01);
      drive_enable = 8'h00;
      acc(1, `DPG_OFS_DUTY, 8'h80);
      wait_sig(0);
      repeat (2) @(negedge core_clk);
      drive_enable = 8'h01;
      wait_sig(2);
      check("enable latency", 16'h0001, 16'(cnt > 256 && cnt <= PER));
      wait_sig(0);
      repeat (4) @(negedge core_clk);
      acc(1, `DPG_OFS_DUTY, 8'h00);
      check("running after stop", 16'h0001, 16'(pwm_running));
      wait_sig(1);
      check("stop delay", 16'h0001, 16'(cnt > PER - 16 && cnt <= PER));
      acc(1, `DPG_OFS_PRESCALE, 8'h01);
      acc(1, `DPG_OFS_DUTY, 8'h80);
      wait_sig(0);
      wait_sig(3);
      check("high time", 16'(128 * DIV * 2), 16'(cnt));
      wait_sig(0);
      check("low time", 16'(PER * 2 - 128 * DIV * 2), 16'(cnt));
      acc(0, `DPG_OFS_STATUS, 8'h00);
      check("status", 16'h0007, 16'(reg_rdata));
      repeat (39) @(negedge core_clk);
      // Read 42 clocks after the zero crossing: ten steps of four clocks
      acc(0, `DPG_OFS_COUNT, 8'h00);
      check("count", 16'h000a, 16'(reg_rdata));
      sleep_entry = 1'b1;
      @(negedge core_clk);
      sleep_entry = 1'b0;
      acc(0, `DPG_OFS_MOD_EN, 8'h00);
      check("enables after sleep", 16'h0000, 16'(reg_rdata));
      acc(0, `DPG_OFS_DUTY, 8'h00);
      check("duty after sleep", 16'h0000, 16'(reg_rdata));
      acc(0, `DPG_OFS_PRESCALE, 8'h00);
      check("prescale", 16'h0001, 16'(reg_rdata));
      acc(1, 8'h40, 8'h5a);
      acc(0, 8'h40, 8'h00);
      check("unmapped", 16'h0000, 16'(reg_rdata));
      // Host stops the generator before a second, orderly sleep entry
      acc(1, `DPG_OFS_MOD_EN, 8'h01);
      acc(1, `DPG_OFS_DUTY, 8'h80);
      wait_sig(0);
      acc(1, `DPG_OFS_DUTY, 8'h00);
      wait_sig(1);
      check("stopped before sleep", 16'h0000, 16'(pwm_out));
      sleep_entry = 1'b1;
      @(negedge core_clk);
      sleep_entry = 1'b0;
      acc(0, `DPG_OFS_MOD_EN, 8'h00);
      check("enables after orderly sleep", 16'h0000, 16'(reg_rdata));
      wrap_up();
   end
endmodule
